// ===== rtl/imu_cmd_core.v
`timescale 1ns/1ps
`include "imu_cmd_map.vh"
// How it works
// - Packets start 0xa5, header, body, checksum.
// - Header holds spare, address, command nibble.
// - Checksum negates sum of earlier bytes.
// - Multi-byte words go low byte first.
// - Replies begin with echoed header.
// - Data replies end with checksum.
// - Packets at 1 kHz over rate divisor.
// - Baud divisor accepted, any nonzero value applied.
// - Busy transmitter drops new data packets.
// - Ping echoes, or stops streaming silently.
// - Get returns header, register byte, checksum.
// - Set acknowledges only valid applied writes.
// - Index 0xff saves or restores defaults.
// - Start streaming silently; no acks while streaming.
// - Diagnostics fills test registers, then echoes.
// - Get, set, diagnostics ignored while streaming.
// - Ordinary commands finish within 5 ms.
// - Unknown or invalid commands stay silent.
// - Continuous test flags cleared each frame.
// - Quick test runs once at startup.
// - Sequence count advances per packet.
// - Saved auto-stream starts after startup.
// - Character format 8N1, default 115200.
// - Reply on interface last commanded.
module imu_cmd_core #(
  parameter UPDATE_CYCLES = `UPDATE_CYCLES,
  parameter STARTUP_CYCLES = `STARTUP_CYCLES,
  parameter DIAG_CYCLES = `DIAG_CYCLES_DEFAULT
) (
  input wire clk_sys,
  input wire resetn,
  input wire [7:0] rx_data,
  input wire rx_valid,
  input wire rx_from_spi,
  input wire tx_ready,
  input wire bootloader_exit,
  input wire cont_test_fail,
  input wire [15:0] cont_test_code,
  input wire [15:0] self_test_low,
  input wire [23:0] self_test_high,
  output reg [7:0] tx_data_r,
  output reg tx_valid_r,
  output reg tx_last_r,
  output reg tx_to_spi_r,
  output reg stream_pkt_r,
  output reg [7:0] packet_sequence_count_r,
  output reg fault_flag_r,
  output reg streaming_r,
  output reg [7:0] baud_div_r,
  output reg flash_save_r,
  output reg packet_dropped_r
);

// Parser states.
localparam P_HUNT = 4'b0001;
localparam P_HDR = 4'b0010;
localparam P_BODY = 4'b0100;
localparam P_SUM = 4'b1000;
// Reply states.
localparam T_IDLE = 3'b001;
localparam T_SEND = 3'b010;
localparam T_DIAG = 3'b100;

reg [255:0] regs_flat_r;
reg [3:0] pst_r;
reg [2:0] tst_r;
reg [7:0] hdr_r;
reg [7:0] b0_r;
reg [7:0] b1_r;
reg [1:0] bcnt_r;
reg [7:0] sum_r;
reg [7:0] rate_div_r;
reg [7:0] stream_timeout_r;
reg auto_stream_r;
reg [15:0] test_low_r;
reg [15:0] cont_r;
reg [23:0] test_high_r;
reg [7:0] rep0_r;
reg [7:0] rep1_r;
reg [7:0] rep2_r;
reg [1:0] rlen_r;
reg [1:0] ridx_r;
reg [31:0] diag_cnt_r;
reg [31:0] start_cnt_r;
reg startup_done_r;
reg boot_seen_r;
reg pkt_busy_r;
reg [7:0] rd_byte;
reg [1:0] need;
wire update_tick;
wire packet_tick;
wire [3:0] cmd = hdr_r[`HDR_CMD_MSB:`HDR_CMD_LSB];
wire [7:0] sum_in = sum_r + rx_data;

update_divider #(
  .UPDATE_CYCLES(UPDATE_CYCLES)
) u_div (
  .clk_sys(clk_sys),
  .resetn(resetn),
  .rate_div(rate_div_r),
  .update_tick_r(update_tick),
  .packet_tick_r(packet_tick)
);

// Body length per command; zero-byte bodies skip straight to the checksum.
always @* begin
  case (rx_data[`HDR_CMD_MSB:`HDR_CMD_LSB])
    `CMD_GET: need = 2'd1;
    `CMD_SET: need = 2'd2;
    `CMD_DIAG: need = 2'd1;
    default: need = 2'd0;
  endcase
end

// Register read mux; unmapped indices read as zero.
always @* begin
  case (b0_r)
    `REG_RATE_DIV: rd_byte = rate_div_r;
    `REG_BAUD_DIV: rd_byte = baud_div_r;
    `REG_AUTO_STREAM: rd_byte = {7'h0, auto_stream_r};
    `REG_STREAM_TIMEOUT: rd_byte = stream_timeout_r;
    `REG_TEST_LOW: rd_byte = test_low_r[7:0];
    `REG_TEST_LOW + 8'h01: rd_byte = test_low_r[15:8];
    `REG_CONT_TEST: rd_byte = cont_r[7:0];
    `REG_CONT_TEST + 8'h01: rd_byte = cont_r[15:8];
    `REG_TEST_HIGH: rd_byte = test_high_r[7:0];
    `REG_TEST_HIGH + 8'h01: rd_byte = test_high_r[15:8];
    `REG_TEST_HIGH + 8'h02: rd_byte = test_high_r[23:16];
    `REG_STATUS_FLAGS: rd_byte = {4'h0, fault_flag_r, 3'h0};
    default: rd_byte = 8'h00;
  endcase
end

// Main sequencer: parser, executor, reply and stream pacing.
always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    regs_flat_r <= 256'h0;
    pst_r <= P_HUNT;
    tst_r <= T_IDLE;
    hdr_r <= 8'h00;
    b0_r <= 8'h00;
    b1_r <= 8'h00;
    bcnt_r <= 2'd0;
    sum_r <= 8'h00;
    rate_div_r <= `RATE_DIV_DEFAULT;
    baud_div_r <= `BAUD_DIV_DEFAULT;
    stream_timeout_r <= 8'h00;
    auto_stream_r <= 1'b0;
    test_low_r <= 16'h0;
    cont_r <= 16'h0;
    test_high_r <= 24'h0;
    rep0_r <= 8'h00;
    rep1_r <= 8'h00;
    rep2_r <= 8'h00;
    rlen_r <= 2'd0;
    ridx_r <= 2'd0;
    diag_cnt_r <= 32'h0;
    start_cnt_r <= 32'h0;
    startup_done_r <= 1'b0;
    boot_seen_r <= 1'b0;
    pkt_busy_r <= 1'b0;
    tx_data_r <= 8'h00;
    tx_valid_r <= 1'b0;
    tx_last_r <= 1'b0;
    tx_to_spi_r <= 1'b0;
    stream_pkt_r <= 1'b0;
    packet_sequence_count_r <= 8'h00;
    fault_flag_r <= 1'b0;
    streaming_r <= 1'b0;
    flash_save_r <= 1'b0;
    packet_dropped_r <= 1'b0;
  end else begin
    flash_save_r <= 1'b0;
    stream_pkt_r <= 1'b0;
    packet_dropped_r <= 1'b0;
    regs_flat_r <= regs_flat_r;
    if (bootloader_exit) begin
      boot_seen_r <= 1'b1;
    end
    if (boot_seen_r && !startup_done_r) begin
      if (start_cnt_r == STARTUP_CYCLES - 1) begin
        startup_done_r <= 1'b1;
        test_low_r <= self_test_low;
        test_high_r <= self_test_high;
        if (auto_stream_r) begin
          streaming_r <= 1'b1;
        end
      end else begin
        start_cnt_r <= start_cnt_r + 32'h1;
      end
    end
    if (packet_tick && streaming_r) begin
      packet_sequence_count_r <= packet_sequence_count_r + 8'h01;
      if (packet_sequence_count_r == 8'hff) begin
        cont_r <= cont_test_fail ? cont_test_code : 16'h0;
        fault_flag_r <= cont_test_fail;
      end else if (cont_test_fail) begin
        cont_r <= cont_r | cont_test_code;
        fault_flag_r <= 1'b1;
      end
      if (pkt_busy_r || tst_r != T_IDLE) begin
        packet_dropped_r <= 1'b1;
      end else begin
        stream_pkt_r <= 1'b1;
        pkt_busy_r <= 1'b1;
      end
    end
    if (pkt_busy_r && tx_ready) begin
      pkt_busy_r <= 1'b0;
    end
    if (rx_valid) begin
      case (pst_r)
        P_HUNT: begin
          if (rx_data == `START_BYTE) begin
            sum_r <= rx_data;
            pst_r <= P_HDR;
          end
        end
        P_HDR: begin
          hdr_r <= rx_data;
          sum_r <= sum_in;
          bcnt_r <= need;
          pst_r <= (need == 2'd0) ? P_SUM : P_BODY;
        end
        P_BODY: begin
          sum_r <= sum_in;
          if (bcnt_r == 2'd2 || (bcnt_r == 2'd1 && cmd != `CMD_SET)) begin
            b0_r <= rx_data;
          end else begin
            b1_r <= rx_data;
          end
          bcnt_r <= bcnt_r - 2'd1;
          if (bcnt_r == 2'd1) begin
            pst_r <= P_SUM;
          end
        end
        P_SUM: begin
          pst_r <= P_HUNT;
          if (sum_in == 8'h00 && tst_r == T_IDLE) begin
            tx_to_spi_r <= rx_from_spi;
            rep0_r <= hdr_r;
            ridx_r <= 2'd0;
            case (cmd)
              `CMD_PING: begin
                if (streaming_r) begin
                  streaming_r <= 1'b0;
                end else begin
                  rlen_r <= 2'd1;
                  tst_r <= T_SEND;
                end
              end
              `CMD_GET: begin
                if (!streaming_r) begin
                  rep1_r <= rd_byte;
                  rep2_r <= 8'h00 - (hdr_r + rd_byte);
                  rlen_r <= 2'd3;
                  tst_r <= T_SEND;
                end
              end
              `CMD_SET: begin
                if (!streaming_r) begin
                  rlen_r <= 2'd1;
                  tst_r <= T_SEND;
                  case (b0_r)
                    `REG_RATE_DIV: begin
                      if (b1_r >= `RATE_DIV_MIN && b1_r <= `RATE_DIV_MAX) begin
                        rate_div_r <= b1_r;
                      end else begin
                        tst_r <= T_IDLE;
                      end
                    end
                    `REG_BAUD_DIV: begin
                      if (b1_r != 8'h00) begin
                        baud_div_r <= b1_r;
                      end else begin
                        tst_r <= T_IDLE;
                      end
                    end
                    `REG_AUTO_STREAM: auto_stream_r <= b1_r[0];
                    `REG_STREAM_TIMEOUT: stream_timeout_r <= b1_r;
                    `REG_FLASH_OP: begin
                      if (b1_r == `FLASH_SAVE) begin
                        flash_save_r <= 1'b1;
                      end else if (b1_r == `FLASH_RESTORE) begin
                        rate_div_r <= `RATE_DIV_DEFAULT;
                        baud_div_r <= `BAUD_DIV_DEFAULT;
                        auto_stream_r <= 1'b0;
                        stream_timeout_r <= 8'h00;
                      end else begin
                        tst_r <= T_IDLE;
                      end
                    end
                    default: tst_r <= T_IDLE;
                  endcase
                end
              end
              `CMD_STREAM: begin
                streaming_r <= 1'b1;
                packet_sequence_count_r <= 8'h00;
              end
              `CMD_DIAG: begin
                if (!streaming_r) begin
                  diag_cnt_r <= 32'h0;
                  rlen_r <= 2'd1;
                  tst_r <= T_DIAG;
                end
              end
              default: tst_r <= T_IDLE;
            endcase
          end
        end
        default: pst_r <= P_HUNT;
      endcase
    end
    case (tst_r)
      T_IDLE: begin
        tx_valid_r <= 1'b0;
        tx_last_r <= 1'b0;
      end
      T_DIAG: begin
        if (diag_cnt_r == DIAG_CYCLES - 1) begin
          test_low_r <= self_test_low;
          test_high_r <= self_test_high;
          tst_r <= T_SEND;
        end else begin
          diag_cnt_r <= diag_cnt_r + 32'h1;
        end
      end
      T_SEND: begin
        if (!tx_valid_r || tx_ready) begin
          if (tx_valid_r && tx_last_r) begin
            tx_valid_r <= 1'b0;
            tx_last_r <= 1'b0;
            tst_r <= T_IDLE;
          end else begin
            tx_valid_r <= 1'b1;
            tx_data_r <= (ridx_r == 2'd0) ? rep0_r : (ridx_r == 2'd1) ? rep1_r : rep2_r;
            tx_last_r <= (ridx_r + 2'd1 == rlen_r);
            ridx_r <= ridx_r + 2'd1;
          end
        end
      end
      default: tst_r <= T_IDLE;
    endcase
  end
end

endmodule // imu_cmd_core

// ===== rtl/imu_cmd_map.vh
`ifndef IMU_CMD_MAP_VH
`define IMU_CMD_MAP_VH

// Packet framing.
`define START_BYTE 8'ha5
`define HDR_ADDR_MSB 6
`define HDR_ADDR_LSB 4
`define HDR_CMD_MSB 3
`define HDR_CMD_LSB 0

// Command codes.
`define CMD_PING 4'h0
`define CMD_GET 4'h1
`define CMD_SET 4'h2
`define CMD_STREAM 4'h5
`define CMD_DIAG 4'h8

// Register offsets.
`define REG_TEST_LOW 8'h24
`define REG_CONT_TEST 8'h26
`define REG_TEST_HIGH 8'h28
`define REG_STATUS_FLAGS 8'h59
`define REG_STREAM_TIMEOUT 8'h9f
`define REG_RATE_DIV 8'h02
`define REG_BAUD_DIV 8'h03
`define REG_AUTO_STREAM 8'h04
`define REG_FLASH_OP 8'hff
`define FLASH_SAVE 8'h00
`define FLASH_RESTORE 8'h01

// Reset values, limits and the fault bit position.
`define RATE_DIV_DEFAULT 8'h05
`define RATE_DIV_MIN 8'h05
`define RATE_DIV_MAX 8'h0a
`define BAUD_DIV_DEFAULT 8'h08
`define BAUD_MAX 921600
`define STATUS_FAULT_BIT 3

// Timing, in microseconds, milliseconds and clock cycles at 100 MHz.
`define CLK_MHZ 100
`define UPDATE_PERIOD_US 1000
`define UPDATE_CYCLES (`UPDATE_PERIOD_US * `CLK_MHZ)
`define STARTUP_MS 200
`define STARTUP_CYCLES (`STARTUP_MS * 1000 * `CLK_MHZ)
`define CMD_LIMIT_MS 5
`define CMD_LIMIT_CYCLES (`CMD_LIMIT_MS * 1000 * `CLK_MHZ)
`define DIAG_CYCLES_DEFAULT 100000000

`endif

// ===== rtl/update_divider.v
`timescale 1ns/1ps
// Makes the 1 kHz update tick and a packet tick every rate_div updates.
module update_divider #(
  parameter UPDATE_CYCLES = 100000
) (
  input wire clk_sys,
  input wire resetn,
  input wire [7:0] rate_div,
  output reg update_tick_r,
  output reg packet_tick_r
);

reg [31:0] cyc_r;
reg [7:0] upd_r;

// The divisor is sampled at each wrap, so a change lands cleanly.
always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    cyc_r <= 32'h0;
    upd_r <= 8'h0;
    update_tick_r <= 1'b0;
    packet_tick_r <= 1'b0;
  end else begin
    update_tick_r <= 1'b0;
    packet_tick_r <= 1'b0;
    if (cyc_r == UPDATE_CYCLES - 1) begin
      cyc_r <= 32'h0;
      update_tick_r <= 1'b1;
      if (upd_r >= rate_div - 8'h01) begin
        upd_r <= 8'h0;
        packet_tick_r <= 1'b1;
      end else begin
        upd_r <= upd_r + 8'h01;
      end
    end else begin
      cyc_r <= cyc_r + 32'h1;
    end
  end
end

endmodule // update_divider

// ===== verification/host_link_model.sv
`timescale 1ns/1ps
// Host end of the byte link: frames commands and drains reply bytes.
module host_link_model (
  input wire clk_sys,
  input wire stall,
  input wire slow,
  input wire [7:0] tx_data_r,
  input wire tx_valid_r,
  output reg [7:0] rx_data,
  output reg rx_valid,
  output reg rx_from_spi,
  output reg tx_ready
);
  logic [7:0] rep[$];
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_from_spi = 1'b0;
    tx_ready = 1'b1;
  end
  // A reply byte counts only at the edge where ready meets valid.
  always @(posedge clk_sys) begin
    if (tx_valid_r && tx_ready) begin
      rep.push_back(tx_data_r);
    end
  end
  // Ready drops while stalled, or every other cycle when slow.
  always @(negedge clk_sys) begin
    tx_ready <= !stall && !(slow && tx_ready);
  end
  // Idle data shows the inverse of the last byte, so stale bytes never match.
  task put(input logic [7:0] b, input logic spi);
    @(negedge clk_sys);
    rx_data = b;
    rx_valid = 1'b1;
    rx_from_spi = spi;
    @(negedge clk_sys);
    rx_data = ~b;
    rx_valid = 1'b0;
  endtask
  task send(input logic [23:0] b, input int n, input logic spi, input logic bad);
    logic [7:0] s;
    s = 8'ha5;
    put(8'ha5, spi);
    for (int i = 0; i < n; i++) begin
      put(b[8*i+:8], spi);
      s = s + b[8*i+:8];
    end
    put((8'h00 - s) ^ {7'h00, bad}, spi);
  endtask
endmodule // host_link_model

// ===== verification/imu_cmd_core_asserts.sv
`timescale 1ns/1ps
// Watches reply framing and stream pacing at the core ports.
module imu_cmd_core_asserts #(
  parameter UPDATE_CYCLES = 1000
) (
  input wire clk_sys,
  input wire resetn,
  input wire [7:0] rx_data,
  input wire rx_valid,
  input wire tx_ready,
  input wire [7:0] tx_data_r,
  input wire tx_valid_r,
  input wire tx_last_r,
  input wire stream_pkt_r,
  input wire [7:0] packet_sequence_count_r,
  input wire fault_flag_r,
  input wire streaming_r,
  input wire flash_save_r,
  input wire packet_dropped_r
);
  reg [31:0] gap_r;
  reg seen_r;
  wire pkt_ev = stream_pkt_r | packet_dropped_r;
  // Cycles between packet slots; a restart of streaming resyncs the phase.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gap_r <= 32'h0;
      seen_r <= 1'b0;
    end else begin
      gap_r <= (pkt_ev || !streaming_r) ? 32'h0 : gap_r + 32'h1;
      seen_r <= streaming_r && (seen_r || pkt_ev);
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence ping_cmd;
    rx_valid && rx_data == 8'ha5 ##2 rx_valid && rx_data == 8'h00
      ##2 rx_valid && rx_data == 8'h5b;
  endsequence
  sequence echo_only;
    tx_valid_r && tx_data_r == 8'h00 && tx_last_r;
  endsequence
  a_ping_echo: assert property (
    ping_cmd ##0 (!streaming_r && !tx_valid_r) |-> ##2 echo_only)
    else $error("ping not echoed");
  a_valid_hold: assert property (
    tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_data_r) && $stable(tx_last_r))
    else $error("reply byte changed before ready");
  a_last_end: assert property (
    $fell(tx_valid_r) |-> $past(tx_last_r) && $past(tx_ready))
    else $error("reply ended without last byte");
  a_no_stream_ack: assert property (
    $rose(tx_valid_r) |-> !$past(streaming_r))
    else $error("reply while streaming");
  a_seq_step: assert property (
    streaming_r && $past(streaming_r) && $changed(packet_sequence_count_r)
      |-> packet_sequence_count_r == $past(packet_sequence_count_r) + 8'h01)
    else $error("sequence count skipped");
  a_fault_frame: assert property (
    $fell(fault_flag_r) && streaming_r |-> packet_sequence_count_r == 8'h00)
    else $error("fault cleared inside frame");
  a_drop_excl: assert property (
    packet_dropped_r |-> !stream_pkt_r && streaming_r)
    else $error("dropped packet also sent");
  a_flash_pulse: assert property (
    flash_save_r |=> !flash_save_r)
    else $error("flash save not a pulse");
  a_pkt_gap: assert property (
    pkt_ev && seen_r |-> (gap_r + 32'h1) % UPDATE_CYCLES == 0
      && gap_r >= 5 * UPDATE_CYCLES - 1 && gap_r < 10 * UPDATE_CYCLES)
    else $error("packet spacing off");
endmodule // imu_cmd_core_asserts

bind imu_cmd_core imu_cmd_core_asserts #(.UPDATE_CYCLES(UPDATE_CYCLES)) u_chk (
  .clk_sys(clk_sys), .resetn(resetn), .rx_data(rx_data), .rx_valid(rx_valid),
  .tx_ready(tx_ready), .tx_data_r(tx_data_r), .tx_valid_r(tx_valid_r),
  .tx_last_r(tx_last_r), .stream_pkt_r(stream_pkt_r), .fault_flag_r(fault_flag_r),
  .packet_sequence_count_r(packet_sequence_count_r), .streaming_r(streaming_r),
  .flash_save_r(flash_save_r), .packet_dropped_r(packet_dropped_r));

// ===== verification/imu_cmd_core_test.sv
`timescale 1ns/1ps
// Sends framed commands through the host model and checks every answer.
module imu_cmd_core_test;
  localparam UPD = 20;
  reg clk_sys = 0;
  reg resetn = 0;
  reg stall = 0;
  reg slow = 0;
  reg cont_test_fail = 0;
  reg boot_exit = 0;
  reg [15:0] st_low = 16'h1234;
  wire [7:0] rx_data, tx_data_r, packet_sequence_count_r, baud_div_r;
  wire rx_valid, rx_from_spi, tx_ready, tx_valid_r, tx_last_r, tx_to_spi_r;
  wire stream_pkt_r, fault_flag_r, streaming_r, flash_save_r, packet_dropped_r;
  int error_cnt = 0;
  int n_checks = 0;
  int saves = 0;
  int drops = 0;
  always #5 clk_sys = ~clk_sys;
  imu_cmd_core #(.UPDATE_CYCLES(UPD), .STARTUP_CYCLES(50), .DIAG_CYCLES(20)) u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_from_spi(rx_from_spi), .tx_ready(tx_ready), .bootloader_exit(boot_exit),
    .cont_test_fail(cont_test_fail), .cont_test_code(16'h00c3),
    .self_test_low(st_low), .self_test_high(24'h00abcd), .tx_data_r(tx_data_r),
    .tx_valid_r(tx_valid_r), .tx_last_r(tx_last_r), .tx_to_spi_r(tx_to_spi_r),
    .stream_pkt_r(stream_pkt_r), .packet_sequence_count_r(packet_sequence_count_r),
    .fault_flag_r(fault_flag_r), .streaming_r(streaming_r), .baud_div_r(baud_div_r),
    .flash_save_r(flash_save_r), .packet_dropped_r(packet_dropped_r));
  host_link_model u_host (
    .clk_sys(clk_sys), .stall(stall), .slow(slow), .tx_data_r(tx_data_r),
    .tx_valid_r(tx_valid_r), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_from_spi(rx_from_spi), .tx_ready(tx_ready));
  // Pulse outputs are tallied here because a task could miss one cycle.
  always @(posedge clk_sys) begin
    if (flash_save_r) saves++;
    if (packet_dropped_r) drops++;
  end
  task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Waits out the answer window, then compares the whole reply.
  task chk_reply(input logic [7:0] h, input logic [7:0] d, input int n, input int w);
    repeat (w) @(negedge clk_sys);
    chk8("reply length", 8'(n), 8'(u_host.rep.size()));
    if (n > 0) chk8("reply header", h, u_host.rep[0]);
    if (n > 2) chk8("reply data", d, u_host.rep[1]);
    if (n > 2) chk8("reply checksum", 8'h00 - h - d, u_host.rep[2]);
    u_host.rep.delete();
  endtask
  task wait_seq(input logic [7:0] v);
    int k;
    k = 0;
    while (packet_sequence_count_r !== v && k < 40000) begin
      @(negedge clk_sys);
      k++;
    end
    // A wait that runs out is a mismatch, never a silent pass.
    if (k == 40000) chk8("sequence wait", v, packet_sequence_count_r);
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // The run is about 27k cycles; this cuts a hang short well after that.
  initial begin
    #800000;
    error_cnt++;
    results;
  end
  initial begin
    repeat (5) @(negedge clk_sys);
    resetn = 1;
    boot_exit = 1;
    chk8("baud divisor", 8'h08, baud_div_r);
    chk8("reply port", 8'h00, {7'h0, tx_to_spi_r});
    repeat (60) @(negedge clk_sys);
    u_host.send(24'h00, 1, 0, 0);
    chk_reply(8'h00, 0, 1, 20);
    slow = 1;
    u_host.send(24'h0201, 2, 0, 0);
    chk_reply(8'h01, 8'h05, 3, 30);
    slow = 0;
    u_host.send(24'h030302, 3, 1, 0);
    chk_reply(8'h02, 0, 1, 20);
    chk8("baud divisor", 8'h03, baud_div_r);
    chk8("reply port", 8'h01, {7'h0, tx_to_spi_r});
    u_host.send(24'h0b0202, 3, 1, 0);
    chk_reply(0, 0, 0, 20);
    u_host.send(24'h03, 1, 0, 0);
    chk_reply(0, 0, 0, 20);
    u_host.send(24'h00, 1, 0, 1);
    u_host.send(24'h00, 1, 0, 0);
    chk_reply(8'h00, 0, 1, 20);
    u_host.send(24'h01ff02, 3, 0, 0);
    chk_reply(8'h02, 0, 1, 20);
    chk8("baud divisor", 8'h08, baud_div_r);
    u_host.send(24'h00ff02, 3, 0, 0);
    chk_reply(8'h02, 0, 1, 20);
    chk8("flash saves", 8'h01, 8'(saves));
    u_host.send(24'h2401, 2, 0, 0);
    chk_reply(8'h01, 8'h34, 3, 30);
    // A new test value shows that diagnostics really relatch the results.
    st_low = 16'h5678;
    u_host.send(24'h0408, 2, 0, 0);
    chk_reply(8'h08, 0, 1, 70);
    u_host.send(24'h2401, 2, 0, 0);
    chk_reply(8'h01, 8'h78, 3, 30);
    u_host.send(24'h2501, 2, 0, 0);
    chk_reply(8'h01, 8'h56, 3, 30);
    u_host.send(24'h05, 1, 0, 0);
    chk_reply(0, 0, 0, 20);
    chk8("streaming", 8'h01, {7'h0, streaming_r});
    u_host.send(24'h2601, 2, 0, 0);
    chk_reply(0, 0, 0, 20);
    wait_seq(8'h80);
    cont_test_fail = 1;
    wait_seq(8'h81);
    cont_test_fail = 0;
    repeat (2) @(negedge clk_sys);
    chk8("fault flag", 8'h01, {7'h0, fault_flag_r});
    stall = 1;
    repeat (20 * UPD) @(negedge clk_sys);
    stall = 0;
    chk8("drops seen", 8'h01, {7'h0, drops > 0});
    wait_seq(8'h01);
    chk8("fault flag", 8'h00, {7'h0, fault_flag_r});
    u_host.send(24'h00, 1, 0, 0);
    chk_reply(0, 0, 0, 20);
    chk8("streaming", 8'h00, {7'h0, streaming_r});
    // Second reset: arm auto-stream before the boot exit, then let startup finish.
    resetn = 0;
    boot_exit = 0;
    repeat (2) @(negedge clk_sys);
    resetn = 1;
    u_host.send(24'h010402, 3, 0, 0);
    chk_reply(8'h02, 0, 1, 20);
    chk8("streaming", 8'h00, {7'h0, streaming_r});
    boot_exit = 1;
    repeat (60) @(negedge clk_sys);
    chk8("streaming", 8'h01, {7'h0, streaming_r});
    results;
  end
endmodule // imu_cmd_core_test
